// ### src/setw_pkg.sv
/*
 * Shared constants and types for the two-wire serial memory target.
 * Assumes a 200 MHz system clock; the program cycle count here is in those cycles.
 */
package setw_pkg;

    // Fixed one-zero type pattern in the top nibble of the device word.
    localparam logic [3:0] DEV_TYPE = 4'ha;

    // Field positions inside the device address word.
    localparam int DEV_RW_BIT = 0;
    localparam int DEV_SEL_LSB = 1;
    localparam int DEV_TYPE_LSB = 4;

    // Bits per byte before the acknowledge slot.
    localparam logic [3:0] BITS_DONE = 4'h8;

    // Self-timed program cycle: the longest time, rounded down.
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

    // Default density in kilobits.
    localparam int DENSITY_DEFAULT = 8;

    // Compare masks for the chip select bits per density.
    localparam logic [2:0] SEL_MASK_SMALL = 3'h7;
    localparam logic [2:0] SEL_MASK_4K = 3'h6;
    localparam logic [2:0] SEL_MASK_8K = 3'h4;

    // Protocol states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV = 4'h1,
        ST_ADEV = 4'h3,
        ST_WADR = 4'h2,
        ST_AWA = 4'h6,
        ST_WDAT = 4'h7,
        ST_AWD = 4'h5,
        ST_RDAT = 4'h4,
        ST_RACK = 4'hc
    } setw_state_t;

endpackage

// ### src/setw_page_buf.sv
/*
 * Page buffer: a small write-then-drain byte store.
 * Assumes a single clock; read data come out of a register one cycle late.
 */
`timescale 1ns/1ps

module setw_page_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Write port
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clock_i)
    begin
        if (we_i)
        begin
            store[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= store[raddr_i];
        end
    end

endmodule // setw_page_buf

// ### src/setw_target.sv
/*
 * Two-wire target of a small byte-wide nonvolatile memory: address match,
 * byte and page writes through a page buffer, the timed program cycle,
 * acknowledge polling and current, random and sequential reads.
 * Assumes the storage array sits outside on clock_i, returns read data one
 * cycle after mem_addr_o settles, and takes one byte per mem_we_o pulse.
 * The serial clock is the link clock; the pad resolves sda from sda_oe_o.
 */
// Operation
// - A device address word of eight bits follows each start.
// - Accept the word only with the fixed type pattern on top.
// - Small densities compare all three select bits with the pins.
// - 4K compares two select bits; the lowest is an address bit.
// - 8K compares one select bit; the next two pick the page.
// - Word bit zero picks direction: one reads, zero writes.
// - Match gives a low acknowledge; a mismatch returns silently to idle.
// - Byte write: word address and one data byte, each acknowledged.
// - After the write stop, program internally and answer nothing.
// - Program time runs from the stop to the end of programming.
// - Page buffer holds 8 or 16 bytes by density.
// - Up to 7 or 15 further bytes may follow, each acknowledged.
// - Writes bump only the low page bits and wrap inside the page.
// - Polling gets an acknowledge only once programming has ended.
// - The address counter holds last address plus one between operations.
// - Reads wrap at the memory end; writes wrap within the page.
// - Current read sends the byte at the counter after acknowledging.
// - Random read is a dummy write then a repeated start and read.
// - Each host acknowledge brings the next byte; a nack ends it.
// - On 1K the top word address bit is ignored.
// - Bytes are eight bits; the receiver pulls low in the ninth.
// - Data falling with clock high starts; rising with clock high stops.
`timescale 1ns/1ps

module setw_target
    import setw_pkg::*;
#(
    parameter int DENSITY_KB = DENSITY_DEFAULT,
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // System clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Two-wire link
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Hardwired select pins
    input wire logic chip_select_pin_high_i,
    input wire logic chip_select_pin_mid_i,
    input wire logic chip_select_pin_low_i,
    // Storage array
    output logic [((DENSITY_KB == 1) ? 7 : (DENSITY_KB == 2) ? 8 :
                   (DENSITY_KB == 4) ? 9 : 10)-1:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_we_o,
    input wire logic [7:0] mem_rdata_i,
    // Status
    output logic prog_busy_o
);

    localparam int ADDR_W = (DENSITY_KB == 1) ? 7 : (DENSITY_KB == 2) ? 8 :
                            (DENSITY_KB == 4) ? 9 : 10;
    localparam int PW = (DENSITY_KB >= 4) ? 4 : 3;
    localparam int PAGE = 1 << PW;
    localparam logic [2:0] SEL_MASK = (DENSITY_KB == 4) ? SEL_MASK_4K :
        (DENSITY_KB == 8) ? SEL_MASK_8K : SEL_MASK_SMALL;
    localparam int CW = $clog2(PROG_CYCLES_P + 1);
    localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES_P - 1);

    // Link domain: the serial clock samples data on its rising edge.
    logic link_bit;
    logic link_tog;

    always_ff @(posedge scl_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            link_bit <= 1'b0;
            link_tog <= 1'b0;
        end
        else
        begin
            link_bit <= sda_i;
            link_tog <= ~link_tog;
        end
    end

    // Synchronisers into the system domain.
    logic scl_s1, scl_s2, scl_q;
    logic sda_s1, sda_s2, sda_q;
    logic tog_s1, tog_s2, tog_q;
    logic [2:0] cs_s1, cs_s2;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {scl_s1, scl_s2, scl_q} <= 3'h7;
            {sda_s1, sda_s2, sda_q} <= 3'h7;
            {tog_s1, tog_s2, tog_q} <= 3'h0;
            cs_s1 <= 3'h0;
            cs_s2 <= 3'h0;
        end
        else
        begin
            {scl_s1, scl_s2, scl_q} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_q} <= {sda_i, sda_s1, sda_s2};
            {tog_s1, tog_s2, tog_q} <= {link_tog, tog_s1, tog_s2};
            cs_s1 <= {chip_select_pin_high_i, chip_select_pin_mid_i,
                      chip_select_pin_low_i};
            cs_s2 <= cs_s1;
        end
    end

    // Bus events. The sampled bit is stable until the next rising edge.
    wire start = scl_s2 & scl_q & sda_q & ~sda_s2;
    wire stop = scl_s2 & scl_q & ~sda_q & sda_s2;
    wire scl_fall = scl_q & ~scl_s2;
    wire bit_ev = tog_s2 ^ tog_q;
    wire quiet = ~start & ~stop;

    setw_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] dev, next_dev;
    logic [7:0] txd, next_txd;
    logic [ADDR_W-1:0] addr, next_addr;
    logic oe, next_oe;
    logic wrote, next_wrote;
    logic nack, next_nack;
    logic prog_busy;
    logic [CW-1:0] prog_cnt;
    logic [ADDR_W-1:PW] page_q;
    logic [PW:0] drain_idx;
    logic [PAGE-1:0] valid;

    wire byte_in = scl_fall & (cnt == BITS_DONE) & quiet;
    wire type_ok = shreg[7:DEV_TYPE_LSB] == DEV_TYPE;
    wire [2:0] sel_diff = shreg[DEV_TYPE_LSB-1:DEV_SEL_LSB] ^ cs_s2;
    wire sel_ok = (sel_diff & SEL_MASK) == 3'h0;
    wire dev_hit = type_ok & sel_ok & ~prog_busy;
    // Page bits sit above the word address; 1K drops word bit 7.
    wire [9:0] full_waddr = {dev[2], dev[1], shreg};
    wire load_rd = scl_fall & quiet &
        ((state == ST_ADEV & dev[DEV_RW_BIT]) |
         (state == ST_RACK & ~nack));
    wire buf_we = (state == ST_WDAT) & byte_in;
    wire [ADDR_W-1:0] wr_next = {addr[ADDR_W-1:PW],
        PW'(addr[PW-1:0] + 1'b1)};
    wire prog_go = stop & wrote;
    wire drain_act = drain_idx < (PW+1)'(PAGE);
    wire [PW-1:0] drain_addr = drain_idx[PW-1:0];

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_dev = dev;
        next_txd = txd;
        next_addr = addr;
        next_oe = oe;
        next_wrote = wrote;
        next_nack = nack;
        if (start)
        begin
            next_state = ST_DEV;
            next_cnt = 4'h0;
            next_oe = 1'b0;
        end
        else if (stop)
        begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
            next_wrote = 1'b0;
        end
        else if (load_rd)
        begin
            next_state = ST_RDAT;
            next_txd = mem_rdata_i;
            next_addr = addr + 1'b1;
            next_oe = ~mem_rdata_i[7];
            next_cnt = 4'h0;
        end
        else
        begin
            case (state)
                ST_DEV, ST_WADR, ST_WDAT:
                begin
                    if (bit_ev && cnt != BITS_DONE)
                    begin
                        next_shreg = {shreg[6:0], link_bit};
                        next_cnt = cnt + 4'h1;
                    end
                    if (byte_in)
                    begin
                        next_oe = 1'b1;
                        if (state == ST_DEV)
                        begin
                            next_dev = shreg;
                            next_state = dev_hit ? ST_ADEV : ST_IDLE;
                            next_oe = dev_hit;
                        end
                        else if (state == ST_WADR)
                        begin
                            next_addr = full_waddr[ADDR_W-1:0];
                            next_state = ST_AWA;
                        end
                        else
                        begin
                            next_addr = wr_next;
                            next_wrote = 1'b1;
                            next_state = ST_AWD;
                        end
                    end
                end
                ST_ADEV, ST_AWA, ST_AWD:
                begin
                    if (scl_fall)
                    begin
                        next_oe = 1'b0;
                        next_cnt = 4'h0;
                        next_state = (state == ST_ADEV) ? ST_WADR :
                            ST_WDAT;
                    end
                end
                ST_RDAT:
                begin
                    if (bit_ev && cnt != BITS_DONE)
                    begin
                        next_cnt = cnt + 4'h1;
                    end
                    if (scl_fall && cnt == BITS_DONE)
                    begin
                        next_oe = 1'b0;
                        next_state = ST_RACK;
                    end
                    else if (scl_fall)
                    begin
                        next_txd = {txd[6:0], 1'b0};
                        next_oe = ~txd[6];
                    end
                end
                ST_RACK:
                begin
                    if (bit_ev)
                    begin
                        next_nack = link_bit;
                    end
                    if (scl_fall)
                    begin
                        next_state = ST_IDLE;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            dev <= 8'h00;
            txd <= 8'h00;
            addr <= '0;
            oe <= 1'b0;
            wrote <= 1'b0;
            nack <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            dev <= next_dev;
            txd <= next_txd;
            addr <= next_addr;
            oe <= next_oe;
            wrote <= next_wrote;
            nack <= next_nack;
        end
    end

    // Program cycle: drains the buffer while the full time counts down.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prog_busy <= 1'b0;
            prog_cnt <= '0;
            page_q <= '0;
            drain_idx <= (PW+1)'(PAGE);
        end
        else if (prog_go)
        begin
            prog_busy <= 1'b1;
            prog_cnt <= PROG_LOAD;
            page_q <= addr[ADDR_W-1:PW];
            drain_idx <= '0;
        end
        else
        begin
            if (prog_busy)
            begin
                prog_busy <= prog_cnt != '0;
                prog_cnt <= prog_cnt - 1'b1;
            end
            if (drain_act)
            begin
                drain_idx <= drain_idx + 1'b1;
            end
        end
    end

    // Loaded-slot flags, one per page entry.
    genvar gi;
    generate
        for (gi = 0; gi < PAGE; gi++)
        begin : g_valid
            always_ff @(posedge clock_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    valid[gi] <= 1'b0;
                end
                else if (buf_we && addr[PW-1:0] == PW'(gi))
                begin
                    valid[gi] <= 1'b1;
                end
                else if (drain_act && drain_addr == PW'(gi))
                begin
                    valid[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    setw_page_buf #(
        .WIDTH(8),
        .DEPTH(PAGE)
    ) u_page_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .we_i(buf_we),
        .waddr_i(addr[PW-1:0]),
        .wdata_i(shreg),
        .raddr_i(drain_addr),
        .rdata_o(mem_wdata_o)
    );

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            mem_addr_o <= '0;
            mem_we_o <= 1'b0;
            prog_busy_o <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            sda_oe_o <= next_oe;
            mem_addr_o <= drain_act ? {page_q, drain_addr} : next_addr;
            mem_we_o <= drain_act & valid[drain_addr];
            prog_busy_o <= prog_busy;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_dev_byte;
        state == ST_DEV && byte_in;
    endsequence

    sequence s_dev_acked;
        state == ST_ADEV ##1 state == ST_ADEV;
    endsequence

    type_mismatch_nack_a: assert property (s_dev_byte and !type_ok |=>
        state == ST_IDLE && !sda_oe_o)
        else $error("wrong type pattern was acknowledged");

    select_match_a: assert property ($changed(state) && state == ST_ADEV
        |-> ((dev[3:1] ^ cs_s2) & SEL_MASK) == 3'h0)
        else $error("select bits acknowledged without a pin match");

    dir_select_a: assert property (state == ST_ADEV && scl_fall && quiet
        |=> state == ($past(dev[0]) ? ST_RDAT : ST_WADR))
        else $error("direction bit not honoured");

    ack_hold_a: assert property (s_dev_acked |-> sda_oe_o)
        else $error("acknowledge not driven low");

    busy_silent_a: assert property (s_dev_byte and prog_busy |=>
        state == ST_IDLE ##1 !sda_oe_o)
        else $error("answered while programming");

    prog_launch_a: assert property (prog_go |=> prog_busy &&
        prog_cnt == PROG_LOAD ##1 prog_busy)
        else $error("program cycle not started by the write stop");

    page_wrap_a: assert property (buf_we |=>
        addr[ADDR_W-1:PW] == $past(addr[ADDR_W-1:PW]) &&
        addr[PW-1:0] == PW'($past(addr[PW-1:0]) + 1'b1))
        else $error("write address left the page");

    read_step_a: assert property (load_rd |=> state == ST_RDAT &&
        addr == ADDR_W'($past(addr) + 1'b1))
        else $error("read address did not advance");

    drain_busy_a: assert property (mem_we_o |-> prog_busy_o)
        else $error("array written outside the program cycle");

    start_restart_a: assert property (start |=> state == ST_DEV &&
        cnt == 4'h0)
        else $error("start did not restart the device word");

endmodule // setw_target

// ### tb/setw_host.sv
/*
 * Two-wire bus controller model that drives the memory target.
 * Assumes a free-running link tick; the resolved wire level comes back.
 */
`timescale 1ns/1ps

module setw_host #(
    parameter int QUARTER = 42
) (
    // Link tick
    input wire logic link_clk_i,
    // Two-wire lines
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    // The serial clock stands high and the data line is released at rest.
    initial
    begin
        scl_o <= 1'b1;
        sda_o <= 1'b1;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk_i);
    endtask

    // Data settles while the clock is low and is sampled mid high.
    task automatic bit_cycle(input logic b, output logic seen);
        sda_o <= b;
        ticks(QUARTER);
        scl_o <= 1'b1;
        ticks(QUARTER);
        seen = sda_i;
        ticks(QUARTER);
        scl_o <= 1'b0;
        ticks(QUARTER);
    endtask

    // Also serves as a repeated start from the low clock phase.
    task automatic start_cond();
        sda_o <= 1'b1;
        ticks(QUARTER);
        scl_o <= 1'b1;
        ticks(QUARTER);
        sda_o <= 1'b0;
        ticks(QUARTER);
        scl_o <= 1'b0;
        ticks(QUARTER);
    endtask

    task automatic stop_cond();
        sda_o <= 1'b0;
        ticks(QUARTER);
        scl_o <= 1'b1;
        ticks(QUARTER);
        sda_o <= 1'b1;
        ticks(2 * QUARTER);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(d[i], s);
        bit_cycle(1'b1, ack);
    endtask

    task automatic recv_byte(input logic host_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(host_ack, s);
    endtask
endmodule // setw_host

// ### tb/setw_tb.sv
/*
 * Self-checking bench for the two-wire memory target at 8K density.
 * Assumes the controller model and a behavioural array beside the target.
 */
`timescale 1ns/1ps

`define SETW_CHK(name, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module testbench;
    localparam int PROG = 6000;
    logic clock_i;
    logic link_clk;
    logic rst_i;
    logic scl;
    logic host_sda;
    wire logic sda_w;
    logic sda_o;
    logic sda_oe_o;
    logic [9:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    logic mem_we_o;
    logic [7:0] mem_rdata;
    logic prog_busy_o;
    logic [7:0] mem_array [0:1023];
    int err_count = 0;
    int compares = 0;
    int cycle_count = 0;
    int busy_cycles = 0;

    // Open-drain wire with a pull-up.
    assign sda_w = (sda_oe_o ? sda_o : 1'b1) & host_sda;

    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial
    begin
        link_clk = 1'b0;
        #1.7;
        forever #6 link_clk = ~link_clk;
    end

    setw_target #(
        .DENSITY_KB(8),
        .PROG_CYCLES_P(PROG)
    ) dut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .scl_i(scl),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .chip_select_pin_high_i(1'b1),
        .chip_select_pin_mid_i(1'b0),
        .chip_select_pin_low_i(1'b1),
        .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o),
        .mem_rdata_i(mem_rdata),
        .prog_busy_o(prog_busy_o)
    );

    setw_host host (
        .link_clk_i(link_clk),
        .scl_o(scl),
        .sda_o(host_sda),
        .sda_i(sda_w)
    );

    function automatic logic [7:0] seed_val(input int a);
        return a[7:0] ^ 8'h5a;
    endfunction

    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Array model with read data one cycle after the address, and timeout.
    always @(posedge clock_i)
    begin
        if (mem_we_o)
            mem_array[mem_addr_o] <= mem_wdata_o;
        mem_rdata <= mem_array[mem_addr_o];
        cycle_count <= cycle_count + 1;
        if (prog_busy_o)
            busy_cycles <= busy_cycles + 1;
        if (cycle_count == 90000)
        begin
            err_count++;
            complete_run();
        end
    end

    task automatic test_reject();
        logic ack;
        host.start_cond();
        host.send_byte(8'hb8, ack);
        `SETW_CHK("type nack", 1'b1, ack)
        host.stop_cond();
        host.start_cond();
        host.send_byte(8'ha0, ack);
        `SETW_CHK("select nack", 1'b1, ack)
        host.stop_cond();
        $display("test_reject done");
    endtask

    // Page bits 10, slot 14 onward, three bytes so the last one wraps.
    task automatic test_page_write();
        logic ack;
        logic [7:0] d [3] = '{8'h11, 8'h22, 8'h33};
        host.start_cond();
        host.send_byte(8'hac, ack);
        `SETW_CHK("dev ack", 1'b0, ack)
        host.send_byte(8'h3e, ack);
        `SETW_CHK("word ack", 1'b0, ack)
        for (int i = 0; i < 3; i++)
        begin
            host.send_byte(d[i], ack);
            `SETW_CHK("data ack", 1'b0, ack)
        end
        host.stop_cond();
        host.start_cond();
        host.send_byte(8'hac, ack);
        `SETW_CHK("poll nack", 1'b1, ack)
        `SETW_CHK("busy in poll", 1'b1, prog_busy_o)
        host.stop_cond();
        for (int n = 0; n < 2 * PROG && prog_busy_o !== 1'b0; n++)
            @(posedge clock_i);
        @(posedge clock_i);
        `SETW_CHK("busy span", PROG, busy_cycles)
        `SETW_CHK("byte 23e", 8'h11, mem_array[10'h23e])
        `SETW_CHK("byte 23f", 8'h22, mem_array[10'h23f])
        `SETW_CHK("wrap 230", 8'h33, mem_array[10'h230])
        `SETW_CHK("next page", seed_val(10'h240), mem_array[10'h240])
        $display("test_page_write done");
    endtask

    task automatic test_current_read();
        logic ack;
        logic [7:0] d;
        host.start_cond();
        host.send_byte(8'ha9, ack);
        `SETW_CHK("read dev ack", 1'b0, ack)
        host.recv_byte(1'b1, d);
        `SETW_CHK("current byte", seed_val(10'h231), d)
        host.stop_cond();
        $display("test_current_read done");
    endtask

    // Dummy write to the last byte, then read across the memory end.
    task automatic test_random_seq();
        logic ack;
        logic [7:0] d;
        host.start_cond();
        host.send_byte(8'hae, ack);
        `SETW_CHK("dummy dev ack", 1'b0, ack)
        host.send_byte(8'hff, ack);
        `SETW_CHK("dummy word ack", 1'b0, ack)
        host.start_cond();
        host.send_byte(8'hab, ack);
        `SETW_CHK("read dir ack", 1'b0, ack)
        host.recv_byte(1'b0, d);
        `SETW_CHK("last byte", seed_val(10'h3ff), d)
        host.recv_byte(1'b1, d);
        `SETW_CHK("rolled byte", seed_val(0), d)
        host.stop_cond();
        `SETW_CHK("released", 1'b0, sda_oe_o)
        $display("test_random_seq done");
    endtask

    initial
    begin
        rst_i <= 1'b1;
        for (int i = 0; i < 1024; i++)
            mem_array[i] <= seed_val(i);
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        `SETW_CHK("idle oe", 1'b0, sda_oe_o)
        test_reject();
        test_page_write();
        test_current_read();
        test_random_seq();
        complete_run();
    end
endmodule // testbench
